// >>> core/wdw_pkg.sv
// Shared constants, register map and decode helpers for the windowed watchdog.
package wdw_pkg;

    // ==========================================================================
    // Clocking and time base
    // ==========================================================================
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 32_000;
    // System clocks per low-power oscillator tick, rounded down.
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int BASE_SHORT_MS = 1;
    localparam int BASE_LONG_MS = 4;
    // Oscillator ticks per base timeout in each prescaler mode.
    localparam int PRE_SHORT = OSC_HZ * BASE_SHORT_MS / 1000;
    localparam int PRE_LONG = OSC_HZ * BASE_LONG_MS / 1000;
    localparam int CNT_W = 23;

    // ==========================================================================
    // Register map
    // ==========================================================================
    localparam int AXI_AW = 4;
    localparam logic [AXI_AW-1:0] ADDR_CFG = 4'h0;
    localparam logic [AXI_AW-1:0] ADDR_RSTCTL = 4'h4;
    localparam logic [AXI_AW-1:0] ADDR_CNT = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Configuration register fields.
    localparam int CFG_POST_LSB = 0;
    localparam int CFG_PRE_BIT = 4;
    localparam int CFG_WIN_BIT = 6;
    localparam int CFG_HWEN_BIT = 7;

    // Reset control register fields and reset values.
    localparam int RSTCTL_IDLE_BIT = 2;
    localparam int RSTCTL_SLEEP_BIT = 3;
    localparam int RSTCTL_TO_BIT = 4;
    localparam int RSTCTL_SWEN_BIT = 5;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_SWEN = 1'b0;

    // Power state of the device as seen by the watchdog.
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_IDLE = 2'h1,
        ST_SLEEP = 2'h3
    } wdw_state_e;

    // True for every word address that holds a register.
    function automatic logic reg_mapped(input logic [AXI_AW-1:0] addr);
        return (addr == ADDR_CFG) || (addr == ADDR_RSTCTL) || (addr == ADDR_CNT);
    endfunction : reg_mapped

endpackage : wdw_pkg

// >>> core/wdw_axil_slave.sv
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/1ps
module wdw_axil_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Write address and data channels
    input wire logic [wdw_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [wdw_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic reg_wr_en,
    output logic [wdw_pkg::AXI_AW-1:0] reg_wr_addr,
    output logic [31:0] reg_wr_data,
    output logic [3:0] reg_wr_strb,
    output logic [wdw_pkg::AXI_AW-1:0] reg_rd_addr,
    input wire logic [31:0] reg_rd_data
);

    logic aw_have_q;
    logic w_have_q;
    logic [wdw_pkg::AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;

    // Each holding slot accepts a new beat only while empty.
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // Write strobes go to the register file once both halves are held and no write response is pending.
    assign reg_wr_en = wr_fire;
    assign reg_wr_addr = awaddr_q;
    assign reg_wr_data = wdata_q;
    assign reg_wr_strb = wstrb_q;
    assign reg_rd_addr = s_axi_araddr;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Address and data may arrive in either order; each is held until used.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have_q)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid && !w_have_q)
            begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_have_q <= 1'b0;
        end
    end

    // Write response, with an error for an unmapped address.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= wdw_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wdw_pkg::reg_mapped(awaddr_q) ? wdw_pkg::RESP_OKAY
                                                     : wdw_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // Read data is captured at the address handshake and held until taken.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= wdw_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= reg_rd_data;
            rresp_q <= wdw_pkg::reg_mapped(s_axi_araddr) ? wdw_pkg::RESP_OKAY
                                                         : wdw_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

endmodule : wdw_axil_slave

// >>> core/wdw_timer.sv
// Windowed watchdog timer with prescaler, postscaler and reset control flags.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Operation
// - Count from the low-power oscillator; enabling the watchdog turns it on.
// - Prescaler divides by 128 when select is 1, by 32 when 0.
// - Base timeout is 1 ms or 4 ms at the nominal oscillator rate.
// - Four-bit postscaler field gives ratios 1:1 up to 1:32,768.
// - Device reset and completed clock switch clear all watchdog counts.
// - Entering and leaving sleep or idle clear all watchdog counts.
// - Clear instruction in normal execution clears all watchdog counts.
// - Watchdog runs in sleep and idle; timeout there wakes the device.
// - Timeout flag stays set until software clears it.
// - Hardware enable forces watchdog and oscillator on; software enable writes ignored.
// - Without hardware enable, software bit starts and stops; reset clears it.
// - In window mode a clear before the last quarter resets the device.
module wdw_timer #(
    parameter int OSC_DIV = wdw_pkg::OSC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite register port
    input wire logic [wdw_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wdw_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Configuration bits
    input wire logic hw_watchdog_enable,
    input wire logic window_disable,
    input wire logic prescale_select,
    input wire logic [3:0] postscale_select,
    // Core events
    input wire logic clear_watchdog_instr,
    input wire logic power_save_instr,
    input wire logic power_save_idle,
    input wire logic wake_event,
    input wire logic sys_reset,
    input wire logic clk_switch_done,
    // Status outputs
    output logic low_power_rc_osc_on,
    output logic dog_reset_req,
    output logic wake_req,
    output logic sleep_active,
    output logic idle_active
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    localparam int DIV_W = $clog2(OSC_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

    logic [DIV_W-1:0] div_q;
    logic [wdw_pkg::CNT_W-1:0] cnt_q;
    logic [wdw_pkg::CNT_W-1:0] per_m1;
    logic [wdw_pkg::CNT_W-1:0] win_open;
    wdw_pkg::wdw_state_e state_q;
    logic swen_q, to_flag_q, sleep_flag_q, idle_flag_q, reset_req_q, wake_req_q;
    logic dog_en, tick, run, timeout, save_enter, save_exit, early_clr, bite, cnt_clr;
    logic reg_wr_en;
    logic [wdw_pkg::AXI_AW-1:0] reg_wr_addr;
    logic [31:0] reg_wr_data;
    logic [3:0] reg_wr_strb;
    logic [wdw_pkg::AXI_AW-1:0] reg_rd_addr;
    logic [31:0] reg_rd_data;
    logic rstctl_wr;

    // Last count of a full period, in oscillator ticks.
    function automatic logic [wdw_pkg::CNT_W-1:0] period_m1(input logic pre,
                                                           input logic [3:0] post);
        logic [wdw_pkg::CNT_W-1:0] base;
        base = pre ? wdw_pkg::CNT_W'(wdw_pkg::PRE_LONG) : wdw_pkg::CNT_W'(wdw_pkg::PRE_SHORT);
        return (base << post) - wdw_pkg::CNT_W'(1);
    endfunction : period_m1

    // ==========================================================================
    // Register bus
    // ==========================================================================
    wdw_axil_slave u_bus (
        .clk(clk),
        .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_strb(reg_wr_strb),
        .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data)
    );

    // Only the low byte of the reset control register holds writable bits.
    assign rstctl_wr = reg_wr_en && (reg_wr_addr == wdw_pkg::ADDR_RSTCTL) && reg_wr_strb[0];

    // Read mux over configuration, reset control and live count.
    always_comb
    begin
        reg_rd_data = '0;
        unique case (reg_rd_addr)
            wdw_pkg::ADDR_CFG:
            begin
                reg_rd_data[wdw_pkg::CFG_POST_LSB +: 4] = postscale_select;
                reg_rd_data[wdw_pkg::CFG_PRE_BIT] = prescale_select;
                reg_rd_data[wdw_pkg::CFG_WIN_BIT] = window_disable;
                reg_rd_data[wdw_pkg::CFG_HWEN_BIT] = hw_watchdog_enable;
            end
            wdw_pkg::ADDR_RSTCTL:
            begin
                reg_rd_data[wdw_pkg::RSTCTL_SWEN_BIT] = swen_q;
                reg_rd_data[wdw_pkg::RSTCTL_TO_BIT] = to_flag_q;
                reg_rd_data[wdw_pkg::RSTCTL_SLEEP_BIT] = sleep_flag_q;
                reg_rd_data[wdw_pkg::RSTCTL_IDLE_BIT] = idle_flag_q;
            end
            wdw_pkg::ADDR_CNT:
                reg_rd_data[wdw_pkg::CNT_W-1:0] = cnt_q;
            default:
                reg_rd_data = '0;
        endcase
    end

    // ==========================================================================
    // Oscillator and counters
    // ==========================================================================
    // hardware enable override
    assign dog_en = hw_watchdog_enable || swen_q;
    assign low_power_rc_osc_on = dog_en;

    // Oscillator tick generator; stopped and zeroed while the oscillator is off.
    always_ff @(posedge clk)
    begin
        if (!resetn || !dog_en)
            div_q <= '0;
        else if (div_q == DIV_LAST)
            div_q <= '0;
        else
            div_q <= div_q + DIV_W'(1);
    end
    assign tick = dog_en && (div_q == DIV_LAST);

    assign per_m1 = period_m1(prescale_select, postscale_select);
    // The window opens after three quarters of the full period.
    assign win_open = (per_m1 + wdw_pkg::CNT_W'(1)) - ((per_m1 + wdw_pkg::CNT_W'(1)) >> 2);

    assign run = (state_q == wdw_pkg::ST_RUN);
    assign timeout = tick && (cnt_q == per_m1);
    assign save_enter = run && power_save_instr;
    assign save_exit = !run && (wake_event || timeout);
    assign early_clr = run && clear_watchdog_instr && dog_en && !window_disable
                       && (cnt_q < win_open);
    assign bite = (run && timeout) || early_clr;

    // power save entry and exit clear
    assign cnt_clr = sys_reset || clk_switch_done || save_enter || save_exit
                     || (run && clear_watchdog_instr) || !dog_en || timeout;

    // Combined prescaler and postscaler count in oscillator ticks.
    always_ff @(posedge clk)
    begin
        if (!resetn || cnt_clr)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + wdw_pkg::CNT_W'(1);
    end

    // ==========================================================================
    // Power state and events
    // ==========================================================================
    // Power state follows the core's power-save instruction and wake events.
    always_ff @(posedge clk)
    begin
        if (!resetn || sys_reset)
            state_q <= wdw_pkg::ST_RUN;
        else
        begin
            unique case (state_q)
                wdw_pkg::ST_RUN:
                    if (power_save_instr)
                        state_q <= power_save_idle ? wdw_pkg::ST_IDLE : wdw_pkg::ST_SLEEP;
                wdw_pkg::ST_IDLE, wdw_pkg::ST_SLEEP:
                    if (save_exit)
                        state_q <= wdw_pkg::ST_RUN;
                default:
                    state_q <= wdw_pkg::ST_RUN;
            endcase
        end
    end
    assign sleep_active = (state_q == wdw_pkg::ST_SLEEP);
    assign idle_active = (state_q == wdw_pkg::ST_IDLE);

    // One-cycle reset and wake requests toward the system.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reset_req_q <= 1'b0;
            wake_req_q <= 1'b0;
        end
        else
        begin
            reset_req_q <= bite;
            wake_req_q <= !run && timeout;
        end
    end
    assign dog_reset_req = reset_req_q;
    assign wake_req = wake_req_q;

    // ==========================================================================
    // Reset control flags
    // ==========================================================================
    // software enable, cleared by any reset
    always_ff @(posedge clk)
    begin
        if (!resetn || sys_reset || bite)
            swen_q <= wdw_pkg::RST_SWEN;
        else if (rstctl_wr && !hw_watchdog_enable)
            swen_q <= reg_wr_data[wdw_pkg::RSTCTL_SWEN_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            to_flag_q <= wdw_pkg::RST_FLAG;
        else if (bite)
            to_flag_q <= 1'b1;
        else if (rstctl_wr && !reg_wr_data[wdw_pkg::RSTCTL_TO_BIT])
            to_flag_q <= 1'b0;
    end

    // power flags left for software to clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sleep_flag_q <= wdw_pkg::RST_FLAG;
            idle_flag_q <= wdw_pkg::RST_FLAG;
        end
        else
        begin
            if (save_enter && !power_save_idle)
                sleep_flag_q <= 1'b1;
            else if (rstctl_wr && !reg_wr_data[wdw_pkg::RSTCTL_SLEEP_BIT])
                sleep_flag_q <= 1'b0;
            if (save_enter && power_save_idle)
                idle_flag_q <= 1'b1;
            else if (rstctl_wr && !reg_wr_data[wdw_pkg::RSTCTL_IDLE_BIT])
                idle_flag_q <= 1'b0;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_woken;
        wake_req ##0 run ##0 (cnt_q == '0);
    endsequence

    sequence s_bitten;
        dog_reset_req ##0 to_flag_q ##0 !swen_q;
    endsequence

    a_osc_forced_on: assert property (hw_watchdog_enable |-> low_power_rc_osc_on)
        else $error("Oscillator off while hardware enable is set.");
    a_short_prescale: assert property (
        !prescale_select && postscale_select == 4'h0 |-> per_m1 == 23'h00001F)
        else $error("Divide-by-32 period count is wrong.");
    a_long_max_period: assert property (
        prescale_select && postscale_select == 4'hF |-> per_m1 == 23'h3FFFFF)
        else $error("Largest period count is wrong.");
    a_timeout_at_end: assert property (
        $rose(dog_reset_req) && !$past(early_clr) |-> $past(cnt_q) == $past(per_m1))
        else $error("Timeout fired before the period ended.");
    a_switch_clears: assert property (clk_switch_done |=> cnt_q == '0)
        else $error("Clock switch left counts standing.");
    a_save_clears: assert property (save_enter |=> !run && cnt_q == '0)
        else $error("Power save entry left counts standing.");
    a_clrwd_clears: assert property (run && clear_watchdog_instr |=> cnt_q == '0)
        else $error("Clear instruction left counts standing.");
    a_sleep_wake: assert property (!run && timeout && dog_en |=> s_woken)
        else $error("Timeout in power save did not wake.");
    a_flag_sticky: assert property (to_flag_q && !rstctl_wr |=> to_flag_q)
        else $error("Timeout flag dropped without software.");
    a_swen_locked: assert property (
        hw_watchdog_enable && !bite && !sys_reset |=> $stable(swen_q))
        else $error("Software enable moved under hardware enable.");
    a_swen_reset: assert property (sys_reset |=> !swen_q)
        else $error("Device reset left software enable set.");
    a_window_bite: assert property (early_clr |=> s_bitten)
        else $error("Early clear in window mode did not reset.");
    a_run_bite: assert property (
        run && timeout && dog_en |=> s_bitten ##1 !dog_reset_req)
        else $error("Normal-mode timeout did not reset for one cycle.");

endmodule : wdw_timer

// >>> testbench/wdw_core_model.sv
// Processor core model that issues watchdog events.
`timescale 1ns/1ps
module wdw_core_model (
    // Clock
    input wire logic clk,
    // Event lines toward the watchdog
    output logic clear_watchdog_instr,
    output logic power_save_instr,
    output logic power_save_idle,
    output logic wake_event,
    output logic sys_reset,
    output logic clk_switch_done
);
    // All event lines rest low.
    initial
    begin
        {clear_watchdog_instr, power_save_instr, power_save_idle} = 3'h0;
        {wake_event, sys_reset, clk_switch_done} = 3'h0;
    end

    // One-cycle event: 0 clear, 1 sleep, 2 idle, 3 switch done, 4 reset, 5 wake.
    task automatic issue(input int kind);
        @(posedge clk);
        clear_watchdog_instr <= (kind == 0);
        power_save_instr <= (kind == 1) || (kind == 2);
        power_save_idle <= (kind == 2);
        clk_switch_done <= (kind == 3);
        sys_reset <= (kind == 4);
        wake_event <= (kind == 5);
        @(posedge clk);
        {clear_watchdog_instr, power_save_instr, power_save_idle} <= 3'h0;
        {wake_event, sys_reset, clk_switch_done} <= 3'h0;
    endtask : issue
endmodule : wdw_core_model

// >>> testbench/wdw_timer_tb.sv
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/1ps
module wdw_timer_tb;
    // ==========================================================================
    // Signals
    // ==========================================================================
    localparam int DIV = 2;
    typedef struct packed {logic pre; logic [3:0] post; int ev; int ticks;} wdw_row_s;
    wdw_row_s rows [4] = '{'{1'b0, 4'h0, 0, 32}, '{1'b1, 4'h0, 3, 128},
        '{1'b0, 4'h2, 4, 128}, '{1'b1, 4'h1, 0, 256}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] strb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic hw_en = 1'b1, win_dis = 1'b1, pre = 1'b1;
    logic [3:0] post = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, osc_on, dog, wreq, slp, idl;
    logic clr, ps, ps_idle, wake, sysr, swdone;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int errors = 0;
    int compares = 0;
    int cyc;

    // Clock at 25 MHz.
    always #20 clk = ~clk;

    wdw_core_model i_core (.clk(clk), .clear_watchdog_instr(clr), .power_save_instr(ps),
        .power_save_idle(ps_idle), .wake_event(wake), .sys_reset(sysr), .clk_switch_done(swdone));

    wdw_timer #(.OSC_DIV(DIV)) i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_watchdog_enable(hw_en), .window_disable(win_dis), .prescale_select(pre),
        .postscale_select(post), .clear_watchdog_instr(clr), .power_save_instr(ps),
        .power_save_idle(ps_idle), .wake_event(wake), .sys_reset(sysr),
        .clk_switch_done(swdone), .low_power_rc_osc_on(osc_on), .dog_reset_req(dog),
        .wake_req(wreq), .sleep_active(slp), .idle_active(idl));

    // ==========================================================================
    // Tasks
    // ==========================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // True when a span in cycles matches so many ticks, within a tick and two cycles.
    function automatic logic near(input int c, input int t);
        return c >= t * DIV - DIV - 2 && c <= t * DIV + DIV + 2;
    endfunction : near

    // Write one word; address and data are released as each is taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {rd, resp} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axi_rd

    // Count cycles until a reset or wake request shows.
    task automatic run_to(input int limit);
        cyc = 0;
        do
        begin
            @(posedge clk);
            cyc++;
        end while (!(dog || wreq) && cyc < limit);
    endtask : run_to

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Cuts a hung run short.
    initial
    begin
        #(40 * 20000);
        errors++;
        print_verdict();
    end

    // ==========================================================================
    // Sequence
    // ==========================================================================
    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        axi_rd(4'h4);
        check("rstctl reset", rd, 32'h0);
        axi_rd(4'h0);
        check("config", rd, 32'hDF);
        axi_rd(4'hC);
        check("unmapped rd", {rd[29:0], resp}, 32'h2);
        axi_wr(4'hC, 32'h0);
        check("unmapped wr", resp, 2'h2);
        foreach (rows[i])
        begin
            {pre, post} <= {rows[i].pre, rows[i].post};
            i_core.issue(rows[i].ev);
            run_to(2000);
            check("period", near(cyc, rows[i].ticks), 1);
            @(posedge clk);
            check("pulse", dog, 1'b0);
        end
        {hw_en, pre, post} <= 6'h0;
        axi_rd(4'h4);
        check("to flag", rd, 32'h10);
        strb <= 4'hE;
        axi_wr(4'h4, 32'h0);
        strb <= 4'hF;
        axi_rd(4'h4);
        check("strobe off", rd, 32'h10);
        axi_wr(4'h4, 32'h0);
        axi_rd(4'h4);
        check("flag clear", rd, 32'h0);
        check("osc off", osc_on, 1'b0);
        axi_rd(4'h8);
        check("count off", rd, 32'h0);
        axi_wr(4'h4, 32'h20);
        check("wr okay", resp, 2'h0);
        @(posedge clk);
        win_dis <= 1'b0;
        check("osc on", osc_on, 1'b1);
        i_core.issue(0);
        run_to(4);
        check("early clear", dog, 1'b1);
        axi_rd(4'h4);
        check("early flag", rd, 32'h10);
        win_dis <= 1'b1;
        axi_wr(4'h4, 32'h20);
        i_core.issue(1);
        @(negedge clk);
        check("sleep", slp, 1'b1);
        run_to(200);
        check("wake", {wreq, near(cyc, 32)}, 2'h3);
        @(negedge clk);
        check("awake", slp, 1'b0);
        axi_rd(4'h4);
        check("sleep flag", rd, 32'h28);
        axi_wr(4'h4, 32'h20);
        i_core.issue(2);
        @(negedge clk);
        check("idle", idl, 1'b1);
        i_core.issue(5);
        run_to(200);
        check("resume", {dog, near(cyc, 32)}, 2'h3);
        i_core.issue(4);
        hw_en <= 1'b1;
        axi_wr(4'h4, 32'h20);
        axi_rd(4'h4);
        check("swen locked", rd & 32'h20, 32'h0);
        check("osc forced", osc_on, 1'b1);
        print_verdict();
    end
endmodule : wdw_timer_tb
